// file: hdl/msb_bridge.sv
// Purpose: Autonomous control of the switches joining a high-speed segment
//          to a legacy-speed segment.
// Assumes: Switch outputs high mean the transistor conducts.
// Notes:   Pass switches change state while the joined lines are high, except on recovery.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Without master code, segments stay joined, current source off.
// - On master code, open data pass first, then enable pull-down.
// - Open clock pass when both clocks high, before fast clock falls.
// - During fast transfer, legacy clock high and legacy data held low.
// - Legacy clock low for recovery time rejoins everything at once.
// - After fast STOP close clock pass, then release pull-down.
// - Close data pass only after legacy data line reads high, except on recovery.
// - Reconnect completely within Fast-mode bus free time.
// - Switching fast enough not to disturb fast lines.
// - Each device follows its own rate or stretches clock low.
// - Reserved code wins arbitration: bridge stays joined.
// - Fast-mode bus free time is 1.3 microseconds.
module msb_bridge
#(
  parameter int RECOVER_CYCLES = msb_pkg::RECOVER_CYC
)
(
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic hsDataPin,
  input  wire logic hsClockPin,
  input  wire logic lsDataPin,
  input  wire logic lsClockPin,
  output var  logic dataPassSwitch,
  output var  logic clockPassSwitch,
  output var  logic dataPulldownSwitch,
  output var  logic masterCurrentSource
);
  import msb_pkg::*;

  msb_line_if lines ();

  msb_state_t       state_q;
  msb_state_t       state_d;
  logic             armed_q;
  logic [3:0]       bitCnt_q;
  logic [7:0]       code_q;
  logic             codeHit;
  logic             recover;
  logic [CNT_W-1:0] lowCnt_q;
  logic [3:0]       fallCnt_q;

  msb_line_monitor u_mon
  (
    .clock      (clock),
    .rst        (rst),
    .hsDataPin  (hsDataPin),
    .hsClockPin (hsClockPin),
    .lsDataPin  (lsDataPin),
    .lsClockPin (lsClockPin),
    .lines      (lines)
  );

  // ****************************************
  // Master code recognition
  // ****************************************
  // Ninth rising edge with data high is the not-acknowledge
  assign codeHit = armed_q && lines.hsClkRise && (bitCnt_q == BYTE_BITS)
                   && (code_q[7:3] == HS_CODE_TOP) && lines.hsData;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      armed_q  <= 1'b0;
      bitCnt_q <= 4'h0;
      code_q   <= 8'h00;
    end
    else if (state_q != MSB_JOINED || lines.hsStop)
    begin
      armed_q  <= 1'b0;
      bitCnt_q <= 4'h0;
    end
    else if (lines.hsStart)
    begin
      armed_q  <= 1'b1;
      bitCnt_q <= 4'h0;
    end
    else if (armed_q && lines.hsClkRise)
    begin
      // Any byte other than the code, reserved ones included, disarms
      if (bitCnt_q == BYTE_BITS)
      begin
        armed_q <= 1'b0;
      end
      else
      begin
        code_q   <= {code_q[6:0], lines.hsData};
        bitCnt_q <= bitCnt_q + 4'h1;
      end
    end
  end

  // ****************************************
  // Recovery window
  // ****************************************
  // Saturating, so a stuck line cannot wrap and miss the threshold
  always_ff @(posedge clock)
  begin
    if (rst || lines.lsClk)
    begin
      lowCnt_q <= '0;
    end
    else if (lowCnt_q < CNT_W'(RECOVER_CYCLES))
    begin
      lowCnt_q <= lowCnt_q + CNT_W'(1);
    end
  end

  assign recover = (lowCnt_q >= CNT_W'(RECOVER_CYCLES));

  // ****************************************
  // Switch sequencing
  // ****************************************
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      MSB_JOINED:
      begin
        if (codeHit)
        begin
          state_d = MSB_SEP_DATA;
        end
      end
      MSB_SEP_DATA:
      begin
        // Pull-down waits for the not-acknowledge clock to end
        if (lines.hsClkFall)
        begin
          state_d = MSB_PULL_LS;
        end
      end
      MSB_PULL_LS:
      begin
        if (lines.hsClk && lines.lsClk)
        begin
          state_d = MSB_HS;
        end
      end
      MSB_HS:
      begin
        if (lines.hsStop)
        begin
          state_d = MSB_CLK_REJ;
        end
      end
      MSB_CLK_REJ:
      begin
        state_d = MSB_WAIT_HI;
      end
      MSB_WAIT_HI:
      begin
        if (lines.lsData)
        begin
          state_d = MSB_JOINED;
        end
      end
      default:
      begin
        state_d = MSB_JOINED;
      end
    endcase
    if (recover && state_q != MSB_JOINED)
    begin
      state_d = MSB_JOINED;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_q <= MSB_JOINED;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Outputs follow the next state so each acts one cycle after its cause
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      dataPassSwitch     <= RST_DATA_PASS;
      clockPassSwitch    <= RST_CLK_PASS;
      dataPulldownSwitch <= RST_PULLDOWN;
    end
    else
    begin
      dataPassSwitch     <= (state_d == MSB_JOINED);
      clockPassSwitch    <= (state_d != MSB_HS);
      dataPulldownSwitch <= (state_d == MSB_PULL_LS)
                            || (state_d == MSB_HS)
                            || (state_d == MSB_CLK_REJ);
    end
  end

  // ****************************************
  // Current source enable for the active master
  // ****************************************
  // Falls counted from the repeated START; the tenth ends the ack bit
  always_ff @(posedge clock)
  begin
    if (rst || state_d != MSB_HS)
    begin
      masterCurrentSource <= RST_MCS;
      fallCnt_q           <= 4'h0;
    end
    else if (state_q != MSB_HS)
    begin
      masterCurrentSource <= 1'b1;
      fallCnt_q           <= 4'h0;
    end
    else if (lines.hsStart)
    begin
      fallCnt_q <= 4'h0;
    end
    else if (lines.hsClkFall)
    begin
      if (fallCnt_q + 4'h1 == ACK_FALL)
      begin
        masterCurrentSource <= 1'b0;
        fallCnt_q           <= FIRST_BIT_CNT;
      end
      else
      begin
        fallCnt_q <= fallCnt_q + 4'h1;
      end
    end
    else if (lines.hsClkRise)
    begin
      masterCurrentSource <= 1'b1;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  localparam int FREE_MAX = BUS_FREE_CYC;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_sep_before_pull: assert property (
    $rose(dataPulldownSwitch) |-> !dataPassSwitch && $past(!dataPassSwitch))
    else $error("pull-down enabled before data separation");
  a_clk_open_high: assert property (
    $fell(clockPassSwitch) |-> $past(lines.hsClk && lines.lsClk))
    else $error("clock pass opened with a clock low");
  a_hs_hold_ls: assert property (
    (state_q == MSB_HS) |-> dataPulldownSwitch && !dataPassSwitch)
    else $error("legacy data not held during fast transfer");
  a_recover_join: assert property (
    (recover && state_q != MSB_JOINED) |=> dataPassSwitch
    && clockPassSwitch && !dataPulldownSwitch)
    else $error("recovery did not rejoin segments");
  a_stop_order: assert property (
    (state_q == MSB_HS && lines.hsStop && !recover) |=> clockPassSwitch
    && dataPulldownSwitch ##1 !dataPulldownSwitch)
    else $error("stop reconnection out of order");
  a_data_close_high: assert property (
    $rose(dataPassSwitch) && (state_q == MSB_JOINED) && $past(!recover)
    |-> $past(lines.lsData))
    else $error("data pass closed with legacy data low");
  a_free_time: assert property (
    (state_q == MSB_HS && lines.hsStop) |-> ##[1:FREE_MAX] dataPassSwitch)
    else $error("reconnection exceeds bus free time");
  a_joined_idle: assert property (
    (state_q == MSB_JOINED) |-> dataPassSwitch && clockPassSwitch
    && !dataPulldownSwitch && !masterCurrentSource)
    else $error("joined state with a switch out of place");
  a_reserved_stay: assert property (
    (armed_q && lines.hsClkRise && bitCnt_q == BYTE_BITS && !code_q[3])
    |=> ##1 (state_q == MSB_JOINED))
    else $error("reserved code separated the segments");
  a_mcs_off_ack: assert property (
    (state_q == MSB_HS && state_d == MSB_HS && lines.hsClkFall
     && !lines.hsStart && fallCnt_q == 4'h9) |=> !masterCurrentSource)
    else $error("current source still on after ack");

  c_hs_entry: cover property ($rose(state_q == MSB_HS));
  c_hs_exit: cover property ((state_q == MSB_WAIT_HI) ##1
                             (state_q == MSB_JOINED));
  c_recovery: cover property (recover && state_q == MSB_HS);
  c_ack_stretch: cover property ($fell(masterCurrentSource)
                                 && state_q == MSB_HS);
endmodule
`default_nettype wire

// file: shared/msb_pkg.sv
// Purpose: Constants and state type for the mixed-speed segment bridge.
// Assumes: 100 MHz local clock.
// Notes:   Times are kept in ns; cycle counts derive from them.
package msb_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int RECOVER_NS    = 1000;
  // Least time: round up
  localparam int RECOVER_CYC   =
    (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUS_FREE_NS   = 1300;
  // Longest time: round down
  localparam int BUS_FREE_CYC  = BUS_FREE_NS / CLK_PERIOD_NS;
  localparam int CNT_W         = 16;

  // ****************************************
  // Code recognition and fall counting
  // ****************************************
  localparam logic [4:0] HS_CODE_TOP   = 5'h01;
  localparam logic [3:0] BYTE_BITS     = 4'h8;
  localparam logic [3:0] ACK_FALL      = 4'hA;
  localparam logic [3:0] FIRST_BIT_CNT = 4'h1;

  // ****************************************
  // Values after reset
  // ****************************************
  localparam logic RST_DATA_PASS = 1'b1;
  localparam logic RST_CLK_PASS  = 1'b1;
  localparam logic RST_PULLDOWN  = 1'b0;
  localparam logic RST_MCS       = 1'b0;

  typedef enum logic [2:0] {
    MSB_JOINED   = 3'h0,
    MSB_SEP_DATA = 3'h1,
    MSB_PULL_LS  = 3'h3,
    MSB_HS       = 3'h2,
    MSB_CLK_REJ  = 3'h6,
    MSB_WAIT_HI  = 3'h4
  } msb_state_t;
endpackage

// file: shared/msb_line_if.sv
// Purpose: Sampled bus levels and events passed from monitor to control.
// Assumes: All members are on the local clock.
// Notes:   Events are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
interface msb_line_if;
  logic hsData;
  logic hsClk;
  logic lsData;
  logic lsClk;
  logic hsClkRise;
  logic hsClkFall;
  logic hsStart;
  logic hsStop;
  modport mon (output hsData, hsClk, lsData, lsClk,
               output hsClkRise, hsClkFall, hsStart, hsStop);
  modport ctl (input hsData, hsClk, lsData, lsClk,
               input hsClkRise, hsClkFall, hsStart, hsStop);
endinterface
`default_nettype wire

// file: hdl/msb_line_monitor.sv
// Purpose: Synchronise the four bus lines and detect fast clock edges, START, STOP.
// Assumes: Lines are asynchronous to the local clock.
// Notes:   Two flip-flops per line before any logic looks at it.
`timescale 1ns/1ps
`default_nettype none
module msb_line_monitor
(
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic hsDataPin,
  input  wire logic hsClockPin,
  input  wire logic lsDataPin,
  input  wire logic lsClockPin,
  msb_line_if.mon   lines
);
  logic [3:0] pins;
  logic [3:0] meta_q;
  logic [3:0] sync_q;
  logic [3:0] prev_q;

  assign pins = {lsClockPin, lsDataPin, hsClockPin, hsDataPin};

  // ****************************************
  // Synchronisers
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_sync
      always_ff @(posedge clock)
      begin
        if (rst)
        begin
          meta_q[gi] <= 1'b1;
          sync_q[gi] <= 1'b1;
          prev_q[gi] <= 1'b1;
        end
        else
        begin
          meta_q[gi] <= pins[gi];
          sync_q[gi] <= meta_q[gi];
          prev_q[gi] <= sync_q[gi];
        end
      end
    end
  endgenerate

  assign lines.hsData    = sync_q[0];
  assign lines.hsClk     = sync_q[1];
  assign lines.lsData    = sync_q[2];
  assign lines.lsClk     = sync_q[3];
  assign lines.hsClkRise = sync_q[1] & ~prev_q[1];
  assign lines.hsClkFall = ~sync_q[1] & prev_q[1];
  // Data moving while clock held high
  assign lines.hsStart   = prev_q[1] & sync_q[1] & prev_q[0] & ~sync_q[0];
  assign lines.hsStop    = prev_q[1] & sync_q[1] & ~prev_q[0] & sync_q[0];
endmodule
`default_nettype wire

// file: tb/msb_bus_model.sv
// Purpose: Far side: fast-segment master and a legacy device.
// Assumes: Pull-ups on all four lines; switch high conducts.
// Notes:   Bus phases are 30 ns steps taken at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module msb_bus_model
(
  input  wire logic clock,
  input  wire logic dataPass,
  input  wire logic clockPass,
  input  wire logic pullLow,
  output var  logic hsData,
  output var  logic hsClock,
  output var  logic lsData,
  output var  logic lsClock
);
  logic mDataLow = 1'b0;
  logic mClockLow = 1'b0;
  logic lsClockLow = 1'b0;
  // ********
  // Wired-AND through the pass switches
  // ********
  assign hsData  = !mDataLow & !(dataPass & pullLow);
  assign lsData  = !pullLow & !(dataPass & mDataLow);
  assign hsClock = !mClockLow & !(clockPass & lsClockLow);
  assign lsClock = !lsClockLow & !(clockPass & mClockLow);

  task automatic ph(input int n);
    repeat (3 * n) @(negedge clock);
  endtask

  task automatic start_cond;
    mDataLow = 1'b0;
    ph(1);
    mClockLow = 1'b0;
    ph(2);
    mDataLow = 1'b1;
    ph(1);
    mClockLow = 1'b1;
    ph(1);
  endtask

  task automatic send_bit(input logic b);
    mDataLow = !b;
    ph(1);
    mClockLow = 1'b0;
    ph(2);
    mClockLow = 1'b1;
    ph(1);
  endtask

  // Ack low stands in for the addressed slave
  task automatic send_byte(input logic [7:0] b, input logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      send_bit(b[i]);
    end
    send_bit(!ack);
  endtask

  task automatic stop_cond;
    mDataLow = 1'b1;
    ph(1);
    mClockLow = 1'b0;
    ph(1);
    mDataLow = 1'b0;
    ph(1);
  endtask
endmodule
`default_nettype wire

// file: tb/mixed_speed_segment_bridge_bench.sv
// Purpose: Self-checking bench for the segment bridge.
// Assumes: Recovery count shortened to keep runs brief.
// Notes:   Outputs are sampled at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module mixed_speed_segment_bridge_bench;
  import msb_pkg::*;
  localparam int REC = 16;
  logic clock;
  logic rst;
  logic hsDataPin;
  logic hsClockPin;
  logic lsDataPin;
  logic lsClockPin;
  logic dp;
  logic cp;
  logic pd;
  logic master_current_source;
  int   n_errors = 0;
  int   n_checks = 0;
  int   c;
  int   t;
  logic pdLast;
  logic dpLast;

  msb_bridge #(.RECOVER_CYCLES(REC)) i_msb_bridge
  (
    .clock(clock), .rst(rst), .hsDataPin(hsDataPin),
    .hsClockPin(hsClockPin), .lsDataPin(lsDataPin),
    .lsClockPin(lsClockPin), .dataPassSwitch(dp),
    .clockPassSwitch(cp), .dataPulldownSwitch(pd),
    .masterCurrentSource(master_current_source)
  );
  msb_bus_model i_msb_bus_model
  (
    .clock(clock), .dataPass(dp), .clockPass(cp), .pullLow(pd),
    .hsData(hsDataPin), .hsClock(hsClockPin), .lsData(lsDataPin),
    .lsClock(lsClockPin)
  );

  // ********
  // Checking helpers
  // ********
  task automatic check_bit(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask

  function automatic logic sel(input int s);
    case (s)
      0: return dp;
      1: return cp;
      2: return pd;
      default: return master_current_source;
    endcase
  endfunction

  // Bounded wait on one switch output, cycles in c
  task automatic wait_out(input int s, input logic v, input int lim);
    c = 0;
    while (sel(s) !== v && c < lim)
    begin
      @(negedge clock);
      c++;
    end
    check_bit("switch wait", v, sel(s));
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Judged from settled values one cycle apart, not in the launching step
  always @(negedge clock)
  begin
    if (pd && !pdLast)
      check_bit("pass open first", 1'b0, dpLast);
    pdLast = pd;
    dpLast = dp;
  end
  always @(negedge cp) check_bit("clocks high", 1'b1, hsClockPin & lsClockPin);

  // ********
  // Scenarios
  // ********
  task automatic t_reset;
    check_bit("dataPass", 1'b1, dp);
    check_bit("clockPass", 1'b1, cp);
    check_bit("pulldown", 1'b0, pd);
    check_bit("mcs", 1'b0, master_current_source);
  endtask

  // Master code, fast byte with ack, then STOP and rejoin
  task automatic t_session;
    i_msb_bus_model.start_cond();
    i_msb_bus_model.send_byte(8'h08, 1'b0);
    wait_out(0, 1'b0, 1);
    wait_out(2, 1'b1, 8);
    check_bit("clockPass low clk", 1'b1, cp);
    i_msb_bus_model.mClockLow = 1'b0;
    wait_out(1, 1'b0, 8);
    wait_out(3, 1'b1, 2);
    i_msb_bus_model.start_cond();
    check_bit("lsClock", 1'b1, lsClockPin);
    check_bit("lsData", 1'b0, lsDataPin);
    i_msb_bus_model.send_byte(8'hA5, 1'b1);
    wait_out(3, 1'b0, 6);
    i_msb_bus_model.mClockLow = 1'b0;
    wait_out(3, 1'b1, 6);
    i_msb_bus_model.ph(1);
    i_msb_bus_model.mDataLow = 1'b0;
    wait_out(1, 1'b1, 8);
    t = c;
    check_bit("pulldown at rejoin", 1'b1, pd);
    check_bit("dataPass at rejoin", 1'b0, dp);
    check_bit("mcs off", 1'b0, master_current_source);
    wait_out(0, 1'b1, 8);
    check_bit("lsData high", 1'b1, lsDataPin);
    check_bit("bus free", 1'b1, t + c <= BUS_FREE_CYC);
  endtask

  // Reserved codes and acknowledged code leave segments joined
  task automatic t_refused;
    logic [7:0] codes [3] = '{8'h00, 8'h07, 8'h08};
    logic       acks  [3] = '{1'b0, 1'b0, 1'b1};
    for (int i = 0; i < 3; i++)
    begin
      i_msb_bus_model.start_cond();
      i_msb_bus_model.send_byte(codes[i], acks[i]);
      i_msb_bus_model.ph(2);
      check_bit("dataPass kept", 1'b1, dp);
      check_bit("pulldown kept", 1'b0, pd);
      check_bit("clockPass kept", 1'b1, cp);
      i_msb_bus_model.stop_cond();
    end
  endtask

  // Legacy clock held low while separated
  task automatic t_recover;
    i_msb_bus_model.start_cond();
    i_msb_bus_model.send_byte(8'h0F, 1'b0);
    i_msb_bus_model.mClockLow = 1'b0;
    wait_out(1, 1'b0, 16);
    i_msb_bus_model.lsClockLow = 1'b1;
    repeat (REC / 2) @(negedge clock);
    check_bit("short low", 1'b0, dp);
    wait_out(0, 1'b1, REC);
    check_bit("recover length", 1'b1, c + REC / 2 >= REC);
    check_bit("clockPass rejoin", 1'b1, cp);
    check_bit("pulldown off", 1'b0, pd);
    i_msb_bus_model.lsClockLow = 1'b0;
    i_msb_bus_model.ph(2);
  endtask

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial
  begin
    #100000;
    n_errors++;
    finish_test();
  end

  initial
  begin
    rst = 1'b1;
    repeat (3) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    t_reset();
    t_refused();
    t_session();
    t_recover();
    finish_test();
  end
endmodule
`default_nettype wire
